// [src/lsc_link_ctrl.sv]
// Contract
// - error-free frame with bad control, info, N(R) or length enters frame reject.
// - with the X.75 option, unsolicited F, unexpected UA/DM, bad N(S) also reject.
// - in frame reject accept no I/S frames, halt I transmission, keep reason.
// - in frame reject, a frame with P=0 or T1 expiry resends FRMR F=0.
// - in frame reject, a frame with P=1 is answered by FRMR F=1.
// - retry count reaching limit in frame reject starts link reset.
// - a received FRMR response always starts a link reset; the code does so only in information transfer and frame reject.
// - SABM, DISC or DM received or sent clears the frame reject condition.
// - received SABM or DISC gets UA, mode change, sequence clear, table disable; the code sends no UA in setup or disconnect and has no table disable.
// - received DM or FRMR starts setup with SABM; FRMR info is stored.
// - DISC to clear frame reject is sent only on the host stop command.
// - fifteen consecutive received ones report channel idle; no idle timer.
// - lacking receive buffers enters busy and sends RNR at first chance.
// - pending I frames keep flowing before and after the RNR while busy.
// - busy clears only on the host load receive table pointer command.
// - listed events, including retries exhausted and collisions, enter disconnect mode; the code has no collision detection.
// - in disconnect mode, link setup starts only on host start command.
// - in disconnect mode, DISC gets DM and SABM gets UA.
// - in disconnect mode, other commands with P get DM F=1; rest ignored.
// - disconnect sends DISC, starts T1, ignores all but SABM, DISC, UA, DM.
// - during disconnect, UA or DM with F=1 stops T1 and enters disconnect.
// - T1 expiry in disconnect resends DISC and counts; at limit give up.
// - T1 starts after each transmitted frame that awaits an answer.
module lsc_link_ctrl
  import lsc_pkg::*;
#(
  parameter int T1_CYCLES = LSC_T1_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic link_clk_i,
  input wire logic rxd_i,
  input wire lsc_rx_t rx_frame_i,
  output lsc_tx_t tx_frame_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic tx_done_i,
  input wire logic start_link_i,
  input wire logic stop_link_i,
  input wire logic load_rtp_i,
  input wire logic rx_buf_short_i,
  input wire logic x75_opt_i,
  input wire logic [LSC_RETRY_W-1:0] retry_limit_i,
  output lsc_state_t link_state_o,
  output logic frmr_active_o,
  output logic [LSC_REASON_W-1:0] frmr_reason_o,
  output logic accept_info_o,
  output logic ifr_tx_halt_o,
  output logic busy_o,
  output logic chan_idle_o,
  output logic status_evt_o,
  output logic seq_clear_o,
  output logic store_frmr_info_o,
  output logic [LSC_RETRY_W-1:0] retry_cnt_o
);

  lsc_state_t state_r;
  lsc_state_t state_nxt;
  logic send;
  lsc_kind_t send_kind;
  logic send_f;
  logic retry_clr;
  logic retry_inc;
  logic seq_clr;
  logic store_info;
  logic t1_stop;
  logic rx_v;
  logic limit_hit;
  logic [LSC_RETRY_W-1:0] retry_r;
  logic [31:0] t1_cnt_r;
  logic t1_run_r;
  logic t1_exp;
  logic tx_pend_r;
  lsc_tx_t tx_r;
  lsc_kind_t fly_kind_r;
  logic rnr_want_r;
  logic busy_r;
  logic [LSC_REASON_W-1:0] reason_r;
  logic status_r;
  logic seq_clr_r;
  logic store_r;
  logic rxd_s1_r;
  logic rxd_s2_r;
  logic [3:0] ones_r;
  logic idle_l_r;
  logic idle_s1_r;
  logic idle_s2_r;

  assign rx_v = rx_frame_i.valid;
  assign limit_hit = (retry_r == retry_limit_i);

  ////////////////////////////////////////////////////////////////////////////
  // link state decisions per received frame, host command and T1 expiry
  always_comb begin
    state_nxt = state_r;
    send = 1'b0;
    send_kind = LSC_K_RR;
    send_f = 1'b0;
    retry_clr = 1'b0;
    retry_inc = 1'b0;
    seq_clr = 1'b0;
    store_info = 1'b0;
    t1_stop = 1'b0;
    case (state_r)
      LSC_ST_ADM: begin
        if (rx_v && rx_frame_i.cmd && rx_frame_i.kind == LSC_K_SABM) begin
          send = 1'b1;
          send_kind = LSC_K_UA;
          send_f = rx_frame_i.pf;
          seq_clr = 1'b1;
          state_nxt = LSC_ST_INFO;
        end else if (rx_v && rx_frame_i.cmd && rx_frame_i.kind == LSC_K_DISC) begin
          send = 1'b1;
          send_kind = LSC_K_DM;
          send_f = rx_frame_i.pf;
        end else if (rx_v && rx_frame_i.cmd && rx_frame_i.pf) begin
          send = 1'b1;
          send_kind = LSC_K_DM;
          send_f = 1'b1;
        end else if (start_link_i) begin
          send = 1'b1;
          send_kind = LSC_K_SABM;
          retry_clr = 1'b1;
          state_nxt = LSC_ST_SETUP;
        end
      end
      LSC_ST_SETUP: begin
        if (rx_v && !rx_frame_i.cmd && rx_frame_i.kind == LSC_K_UA) begin
          t1_stop = 1'b1;
          seq_clr = 1'b1;
          state_nxt = LSC_ST_INFO;
        end else if (rx_v && !rx_frame_i.cmd && rx_frame_i.kind == LSC_K_DM && rx_frame_i.pf) begin
          t1_stop = 1'b1;
          state_nxt = LSC_ST_ADM;
        end else if (rx_v && rx_frame_i.cmd && rx_frame_i.kind == LSC_K_DISC) begin
          t1_stop = 1'b1;
          state_nxt = LSC_ST_ADM;
        end else if (t1_exp) begin
          if (limit_hit) begin
            state_nxt = LSC_ST_ADM;
          end else begin
            send = 1'b1;
            send_kind = LSC_K_SABM;
            retry_inc = 1'b1;
          end
        end
      end
      LSC_ST_INFO, LSC_ST_FRMR: begin
        if (rx_v && rx_frame_i.cmd && rx_frame_i.kind == LSC_K_SABM) begin
          send = 1'b1;
          send_kind = LSC_K_UA;
          send_f = rx_frame_i.pf;
          seq_clr = 1'b1;
          t1_stop = 1'b1;
          state_nxt = LSC_ST_INFO;
        end else if (rx_v && rx_frame_i.cmd && rx_frame_i.kind == LSC_K_DISC) begin
          send = 1'b1;
          send_kind = LSC_K_UA;
          send_f = rx_frame_i.pf;
          seq_clr = 1'b1;
          t1_stop = 1'b1;
          state_nxt = LSC_ST_ADM;
        end else if (rx_v && !rx_frame_i.cmd &&
                     (rx_frame_i.kind == LSC_K_DM || rx_frame_i.kind == LSC_K_FRMR)) begin
          send = 1'b1;
          send_kind = LSC_K_SABM;
          retry_clr = 1'b1;
          store_info = (rx_frame_i.kind == LSC_K_FRMR);
          state_nxt = LSC_ST_SETUP;
        end else if (stop_link_i) begin
          send = 1'b1;
          send_kind = LSC_K_DISC;
          retry_clr = 1'b1;
          state_nxt = LSC_ST_DISC;
        end else if (state_r == LSC_ST_INFO) begin
          if (rx_v && ((|rx_frame_i.err) || (x75_opt_i && (|rx_frame_i.x75_err)))) begin
            send = 1'b1;
            send_kind = LSC_K_FRMR;
            send_f = rx_frame_i.pf;
            retry_clr = 1'b1;
            state_nxt = LSC_ST_FRMR;
          end
        end else if (rx_v) begin
          send = 1'b1;
          send_kind = LSC_K_FRMR;
          send_f = rx_frame_i.pf;
        end else if (t1_exp) begin
          if (limit_hit) begin
            send = 1'b1;
            send_kind = LSC_K_SABM;
            retry_clr = 1'b1;
            state_nxt = LSC_ST_SETUP;
          end else begin
            send = 1'b1;
            send_kind = LSC_K_FRMR;
            retry_inc = 1'b1;
          end
        end
      end
      LSC_ST_DISC: begin
        if (rx_v && !rx_frame_i.cmd &&
            (rx_frame_i.kind == LSC_K_UA || (rx_frame_i.kind == LSC_K_DM && rx_frame_i.pf))) begin
          t1_stop = 1'b1;
          state_nxt = LSC_ST_ADM;
        end else if (rx_v && rx_frame_i.cmd &&
                     (rx_frame_i.kind == LSC_K_SABM || rx_frame_i.kind == LSC_K_DISC)) begin
          t1_stop = 1'b1;
          state_nxt = LSC_ST_ADM;
        end else if (t1_exp) begin
          if (limit_hit) begin
            state_nxt = LSC_ST_ADM;
          end else begin
            send = 1'b1;
            send_kind = LSC_K_DISC;
            retry_inc = 1'b1;
          end
        end
      end
      default: state_nxt = LSC_ST_ADM;
    endcase
  end

  // link state register; disconnect mode once reset completes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= LSC_ST_ADM;
    end else begin
      state_r <= state_nxt;
    end
  end

  // retry counter, cleared at each procedure start
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      retry_r <= LSC_RETRY_RST;
    end else if (retry_clr) begin
      retry_r <= LSC_RETRY_RST;
    end else if (retry_inc) begin
      retry_r <= retry_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit request slot; newest request replaces an unsent one
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_pend_r <= 1'b0;
      tx_r <= '{kind: LSC_K_RR, fbit: 1'b0};
      rnr_want_r <= 1'b0;
      fly_kind_r <= LSC_K_RR;
    end else begin
      if (tx_pend_r && tx_ready_i) begin
        fly_kind_r <= tx_r.kind;
      end
      if (send) begin
        tx_pend_r <= 1'b1;
        tx_r <= '{kind: send_kind, fbit: send_f};
      end else if (rnr_want_r && (!tx_pend_r || tx_ready_i) && state_r == LSC_ST_INFO) begin
        tx_pend_r <= 1'b1;
        tx_r <= '{kind: LSC_K_RNR, fbit: 1'b0};
      end else if (tx_pend_r && tx_ready_i) begin
        tx_pend_r <= 1'b0;
      end
      if (rx_buf_short_i && !busy_r) begin
        rnr_want_r <= 1'b1;
      end else if (!send && (!tx_pend_r || tx_ready_i) && state_r == LSC_ST_INFO) begin
        rnr_want_r <= 1'b0;
      end
    end
  end

  assign tx_valid_o = tx_pend_r;
  assign tx_frame_o = tx_r;

  // T1: loaded after a frame that awaits an answer leaves the line
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      t1_run_r <= 1'b0;
      t1_cnt_r <= 32'h0000_0000;
    end else if (t1_stop || state_nxt == LSC_ST_ADM || state_nxt == LSC_ST_INFO) begin
      t1_run_r <= 1'b0;
    end else if (tx_done_i && (fly_kind_r == LSC_K_SABM || fly_kind_r == LSC_K_DISC ||
                               fly_kind_r == LSC_K_FRMR)) begin
      t1_run_r <= 1'b1;
      t1_cnt_r <= 32'(T1_CYCLES);
    end else if (t1_run_r) begin
      t1_run_r <= (t1_cnt_r != 32'h0000_0001);
      t1_cnt_r <= t1_cnt_r - 32'h0000_0001;
    end
  end

  assign t1_exp = t1_run_r && (t1_cnt_r == 32'h0000_0001);

  ////////////////////////////////////////////////////////////////////////////
  // busy: set while buffers lack, dropped by a receive table reload
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r <= 1'b0;
    end else if (rx_buf_short_i) begin
      busy_r <= 1'b1;
    end else if (load_rtp_i) begin
      busy_r <= 1'b0;
    end
  end

  // reject reason held while the frame reject condition stands
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reason_r <= LSC_REASON_RST;
    end else if (state_r == LSC_ST_INFO && state_nxt == LSC_ST_FRMR) begin
      reason_r <= {rx_frame_i.x75_err & {3{x75_opt_i}}, rx_frame_i.err};
    end else if (state_nxt != LSC_ST_FRMR) begin
      reason_r <= LSC_REASON_RST;
    end
  end

  // host notification pulses
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_r <= 1'b0;
      seq_clr_r <= 1'b0;
      store_r <= 1'b0;
    end else begin
      status_r <= (state_nxt != state_r);
      seq_clr_r <= seq_clr;
      store_r <= store_info;
    end
  end

  assign link_state_o = state_r;
  assign frmr_active_o = (state_r == LSC_ST_FRMR);
  assign frmr_reason_o = reason_r;
  // busy does not halt I frames, they go around the RNR
  assign ifr_tx_halt_o = (state_r != LSC_ST_INFO);
  assign accept_info_o = (state_r == LSC_ST_INFO) && !busy_r;
  assign busy_o = busy_r;
  assign status_evt_o = status_r;
  assign seq_clear_o = seq_clr_r;
  assign store_frmr_info_o = store_r;
  assign retry_cnt_o = retry_r;

  ////////////////////////////////////////////////////////////////////////////
  // idle run of ones counted on the link clock
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxd_s1_r <= 1'b0;
      rxd_s2_r <= 1'b0;
      ones_r <= 4'h0;
      idle_l_r <= 1'b0;
    end else begin
      rxd_s1_r <= rxd_i;
      rxd_s2_r <= rxd_s1_r;
      if (!rxd_s2_r) begin
        ones_r <= 4'h0;
      end else if (ones_r != LSC_IDLE_ONES) begin
        ones_r <= ones_r + 4'h1;
      end
      idle_l_r <= rxd_s2_r && (ones_r >= LSC_IDLE_ONES - 4'h1);
    end
  end

  // idle level into the system clock domain
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_s1_r <= 1'b0;
      idle_s2_r <= 1'b0;
    end else begin
      idle_s1_r <= idle_l_r;
      idle_s2_r <= idle_s1_r;
    end
  end

  assign chan_idle_o = idle_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  frmr_enter_a: assert property (rx_v && state_r == LSC_ST_INFO && (|rx_frame_i.err) &&
    rx_frame_i.kind == LSC_K_I && !stop_link_i |=> state_r == LSC_ST_FRMR && frmr_reason_o != 7'h00)
    else $error("bad frame did not enter frame reject");
  x75_enter_a: assert property (rx_v && state_r == LSC_ST_INFO && rx_frame_i.err == 4'h0 &&
    rx_frame_i.kind inside {LSC_K_I, LSC_K_RR, LSC_K_RNR, LSC_K_REJ} && !stop_link_i
    |=> (state_r == LSC_ST_FRMR) == $past(x75_opt_i && (|rx_frame_i.x75_err)))
    else $error("x75 reject entry wrong");
  frmr_halt_a: assert property (state_r == LSC_ST_FRMR |-> !accept_info_o && ifr_tx_halt_o)
    else $error("frame reject does not halt traffic");
  frmr_resend_a: assert property (rx_v && state_r == LSC_ST_FRMR && rx_frame_i.kind == LSC_K_I
    && !stop_link_i |=> tx_valid_o && tx_frame_o.kind == LSC_K_FRMR && tx_frame_o.fbit == $past(rx_frame_i.pf))
    else $error("frame reject resend wrong");
  frmr_limit_a: assert property (state_r == LSC_ST_FRMR && t1_exp && limit_hit && !rx_v
    && !stop_link_i |=> state_r == LSC_ST_SETUP && tx_frame_o.kind == LSC_K_SABM)
    else $error("retry limit did not reset link");
  frmr_rx_a: assert property (rx_v && !rx_frame_i.cmd && rx_frame_i.kind == LSC_K_FRMR &&
    (state_r == LSC_ST_INFO || state_r == LSC_ST_FRMR) |=> state_r == LSC_ST_SETUP ##0 store_frmr_info_o)
    else $error("received reject did not start reset");
  seq_clear_a: assert property (rx_v && rx_frame_i.cmd && rx_frame_i.kind == LSC_K_SABM &&
    state_r != LSC_ST_SETUP && state_r != LSC_ST_DISC |=> seq_clear_o)
    else $error("sequence clear missing");
  stop_disc_a: assert property ($rose(state_r == LSC_ST_DISC) |-> $past(stop_link_i))
    else $error("disconnect without host stop");
  busy_hold_a: assert property (busy_o && !load_rtp_i |=> busy_o)
    else $error("busy left without reload");
  adm_disc_a: assert property (rx_v && state_r == LSC_ST_ADM && rx_frame_i.cmd &&
    rx_frame_i.kind == LSC_K_DISC |=> tx_frame_o.kind == LSC_K_DM && state_r == LSC_ST_ADM)
    else $error("disconnect mode did not answer DM");
  disc_retry_a: assert property (state_r == LSC_ST_DISC && t1_exp && !limit_hit && !rx_v
    |=> retry_cnt_o == $past(retry_cnt_o) + 8'h01 && tx_frame_o.kind == LSC_K_DISC)
    else $error("disconnect retry count wrong");
  idle_run_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
    rxd_s2_r && ones_r == 4'he |=> idle_l_r)
    else $error("idle run not reported");

  frmr_seen_c: cover property (state_r == LSC_ST_INFO ##1 state_r == LSC_ST_FRMR);
  disc_seen_c: cover property (state_r == LSC_ST_DISC ##1 state_r == LSC_ST_ADM);
  busy_seen_c: cover property ($rose(busy_o));
  idle_seen_c: cover property ($rose(chan_idle_o));

endmodule

// [include/lsc_pkg.sv]
package lsc_pkg;

  // frame kinds as seen by the decoder and requested from the encoder
  typedef enum logic [3:0] {
    LSC_K_I    = 4'h0,
    LSC_K_RR   = 4'h1,
    LSC_K_RNR  = 4'h2,
    LSC_K_REJ  = 4'h3,
    LSC_K_SABM = 4'h4,
    LSC_K_DISC = 4'h5,
    LSC_K_UA   = 4'h6,
    LSC_K_DM   = 4'h7,
    LSC_K_FRMR = 4'h8,
    LSC_K_OTH  = 4'h9
  } lsc_kind_t;

  // link states, one-hot
  typedef enum logic [4:0] {
    LSC_ST_ADM   = 5'h01,
    LSC_ST_SETUP = 5'h02,
    LSC_ST_INFO  = 5'h04,
    LSC_ST_FRMR  = 5'h08,
    LSC_ST_DISC  = 5'h10
  } lsc_state_t;

  // one error-free received frame, already decoded
  typedef struct packed {
    logic valid;
    lsc_kind_t kind;
    logic cmd;
    logic pf;
    logic [3:0] err;
    logic [2:0] x75_err;
  } lsc_rx_t;

  // one frame the encoder is asked to send
  typedef struct packed {
    lsc_kind_t kind;
    logic fbit;
  } lsc_tx_t;

  localparam int LSC_REASON_W = 7;
  localparam int LSC_RETRY_W = 8;
  localparam logic [3:0] LSC_IDLE_ONES = 4'hf;
  localparam int LSC_CLK_PERIOD_NS = 10;
  localparam int LSC_T1_TIME_US = 1000;
  localparam int LSC_T1_CYCLES = LSC_T1_TIME_US * 1000 / LSC_CLK_PERIOD_NS;
  localparam logic [LSC_RETRY_W-1:0] LSC_RETRY_RST = 8'h00;
  localparam logic [LSC_REASON_W-1:0] LSC_REASON_RST = 7'h00;

endpackage

// [sim/lsc_remote_model.sv]
module lsc_remote_model
  import lsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic link_clk_i,
  input wire logic tx_valid_i,
  input wire lsc_tx_t tx_frame_i,
  input wire logic slow_i,
  input wire logic idle_i,
  output logic tx_ready_o,
  output logic tx_done_o,
  output logic rxd_o,
  output lsc_tx_t last_o,
  output logic [7:0] taken_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] stall_r;
  logic [2:0] done_r;
  logic [7:0] flag_r;

  ////////////////////////////////////////////////////////////////////////////////
  // grant at once or after a five cycle stall; line finishes four cycles later
  assign tx_ready_o = tx_valid_i && (!slow_i || stall_r == 3'h5);
  assign tx_done_o = done_r == 3'h1;

  // take requests, keep the last frame and a running count
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stall_r <= 3'h0;
      done_r <= 3'h0;
      last_o <= '0;
      taken_o <= 8'h00;
    end else if (tx_ready_o) begin
      stall_r <= 3'h0;
      done_r <= 3'h4; // newest frame owns the done pulse
      last_o <= tx_frame_i;
      taken_o <= taken_o + 8'h01;
    end else begin
      if (tx_valid_i && stall_r != 3'h5) stall_r <= stall_r + 3'h1;
      if (done_r != 3'h0) done_r <= done_r - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags between frames keep runs of ones short; idle sends only ones
  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_r <= 8'h7e;
    end else begin
      flag_r <= {flag_r[0], flag_r[7:1]};
    end
  end
  assign rxd_o = idle_i | flag_r[0];
endmodule

// [sim/lapb_link_state_control_bench.sv]
module lapb_link_state_control_bench;
  import lsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic arst_n_i = 1'b0;
  lsc_rx_t rx_frame = '0;
  logic start_link = 1'b0;
  logic stop_link = 1'b0;
  logic load_rtp = 1'b0;
  logic buf_short = 1'b0;
  logic x75_opt = 1'b0;
  logic [7:0] retry_limit = 8'h02;
  logic slow = 1'b0;
  logic idle = 1'b0;
  lsc_tx_t tx_frame;
  lsc_tx_t last;
  lsc_state_t state;
  logic tx_valid, tx_ready, tx_done, rxd, frmr_act, accept, halt, busy;
  logic chan_idle, evt, seq_clr, store;
  logic [6:0] reason;
  logic [7:0] retry_cnt, taken, take_b, seq_b, store_b, evt_b;
  logic [7:0] seq_n = 8'h00;
  logic [7:0] store_n = 8'h00;
  logic [7:0] evt_n = 8'h00;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // system clock and an unrelated line clock
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  lsc_link_ctrl #(.T1_CYCLES(20)) lsc_link_ctrl_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk), .rxd_i(rxd),
    .rx_frame_i(rx_frame), .tx_frame_o(tx_frame), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_ready), .tx_done_i(tx_done), .start_link_i(start_link),
    .stop_link_i(stop_link), .load_rtp_i(load_rtp), .rx_buf_short_i(buf_short),
    .x75_opt_i(x75_opt), .retry_limit_i(retry_limit), .link_state_o(state),
    .frmr_active_o(frmr_act), .frmr_reason_o(reason), .accept_info_o(accept),
    .ifr_tx_halt_o(halt), .busy_o(busy), .chan_idle_o(chan_idle),
    .status_evt_o(evt), .seq_clear_o(seq_clr), .store_frmr_info_o(store),
    .retry_cnt_o(retry_cnt));

  lsc_remote_model lsc_remote_model_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk),
    .tx_valid_i(tx_valid), .tx_frame_i(tx_frame), .slow_i(slow), .idle_i(idle),
    .tx_ready_o(tx_ready), .tx_done_o(tx_done), .rxd_o(rxd), .last_o(last),
    .taken_o(taken));

  // count pulses so checks do not hinge on their exact cycle
  always @(posedge clk_i) begin
    seq_n <= seq_n + 8'(seq_clr);
    store_n <= store_n + 8'(store);
    evt_n <= evt_n + 8'(evt);
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare helpers and report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_tx(input lsc_kind_t k, input logic f);
    samples_checked++;
    if (last !== {k, f}) begin
      err_total++;
      $display("wrong value tx frame expected %h seen %h", {k, f}, last);
    end
  endtask

  task automatic endtest(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // frame and host command drivers
  task automatic snap;
    take_b = taken;
    seq_b = seq_n;
    store_b = store_n;
    evt_b = evt_n;
  endtask

  task automatic rx(input lsc_kind_t k, input logic c, input logic p,
                    input logic [3:0] e = 4'h0, input logic [2:0] x = 3'h0);
    @(posedge clk_i);
    snap();
    rx_frame <= '{1'b1, k, c, p, e, x};
    @(posedge clk_i);
    rx_frame.valid <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic host(input int w);
    @(posedge clk_i);
    snap();
    case (w)
      0: start_link <= 1'b1;
      1: stop_link <= 1'b1;
      default: load_rtp <= 1'b1;
    endcase
    @(posedge clk_i);
    start_link <= 1'b0;
    stop_link <= 1'b0;
    load_rtp <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic wait_tx(input logic [7:0] n, input int lim);
    for (int i = 0; i < lim && 8'(taken - take_b) != n; i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("state", 8'(LSC_ST_ADM), 8'(state));
    chk("retry", 8'h00, retry_cnt);
    endtest("reset");
    // disconnected mode answers
    rx(LSC_K_DISC, 1'b1, 1'b0);
    chk("dm kind", 8'(LSC_K_DM), 8'(last.kind));
    chk("state", 8'(LSC_ST_ADM), 8'(state));
    rx(LSC_K_RR, 1'b1, 1'b1);
    chk_tx(LSC_K_DM, 1'b1);
    rx(LSC_K_UA, 1'b0, 1'b1);
    chk("ignored", 8'h00, 8'(taken - take_b));
    rx(LSC_K_RR, 1'b1, 1'b0);
    chk("ignored", 8'h00, 8'(taken - take_b));
    host(0);
    chk("state", 8'(LSC_ST_SETUP), 8'(state));
    chk("sabm", 8'(LSC_K_SABM), 8'(last.kind));
    rx(LSC_K_UA, 1'b0, 1'b1);
    chk("state", 8'(LSC_ST_INFO), 8'(state));
    endtest("disconnected");
    // frame reject entry and replies
    rx(LSC_K_I, 1'b1, 1'b0, 4'h5);
    chk("state", 8'(LSC_ST_FRMR), 8'(state));
    chk_tx(LSC_K_FRMR, 1'b0);
    chk("reason", 8'h05, 8'(reason));
    chk("halt", 8'h01, 8'(halt));
    chk("accept", 8'h00, 8'(accept));
    rx(LSC_K_RR, 1'b1, 1'b1);
    chk_tx(LSC_K_FRMR, 1'b1);
    rx(LSC_K_I, 1'b1, 1'b0);
    chk_tx(LSC_K_FRMR, 1'b0);
    chk("state", 8'(LSC_ST_FRMR), 8'(state));
    snap();
    wait_tx(8'h01, 60);
    chk_tx(LSC_K_FRMR, 1'b0);
    rx(LSC_K_SABM, 1'b1, 1'b1);
    chk_tx(LSC_K_UA, 1'b1);
    chk("state", 8'(LSC_ST_INFO), 8'(state));
    chk("seq clear", 8'h01, 8'(seq_n - seq_b));
    chk("reason", 8'h00, 8'(reason));
    endtest("frame reject");
    // option causes, remote DM and remote FRMR
    rx(LSC_K_RR, 1'b0, 1'b1, 4'h0, 3'h1);
    chk("state", 8'(LSC_ST_INFO), 8'(state));
    x75_opt <= 1'b1;
    rx(LSC_K_RR, 1'b0, 1'b1, 4'h0, 3'h1);
    chk("state", 8'(LSC_ST_FRMR), 8'(state));
    chk("reason", 8'h10, 8'(reason));
    x75_opt <= 1'b0;
    rx(LSC_K_DM, 1'b0, 1'b0);
    chk("state", 8'(LSC_ST_SETUP), 8'(state));
    chk("sabm", 8'(LSC_K_SABM), 8'(last.kind));
    rx(LSC_K_UA, 1'b0, 1'b1);
    rx(LSC_K_FRMR, 1'b0, 1'b0);
    chk("state", 8'(LSC_ST_SETUP), 8'(state));
    chk("sabm", 8'(LSC_K_SABM), 8'(last.kind));
    chk("store", 8'h01, 8'(store_n - store_b));
    rx(LSC_K_UA, 1'b0, 1'b1);
    endtest("option and remote reject");
    // retries run out in frame reject
    rx(LSC_K_I, 1'b1, 1'b0, 4'h1);
    wait_tx(8'h04, 300);
    chk("state", 8'(LSC_ST_SETUP), 8'(state));
    chk("sabm", 8'(LSC_K_SABM), 8'(last.kind));
    chk("retry", 8'h00, retry_cnt);
    rx(LSC_K_UA, 1'b0, 1'b1);
    endtest("reject retries");
    // busy with a stalling far side
    slow <= 1'b1;
    buf_short <= 1'b1;
    snap();
    wait_tx(8'h01, 40);
    chk("busy", 8'h01, 8'(busy));
    chk("rnr", 8'(LSC_K_RNR), 8'(last.kind));
    chk("accept", 8'h00, 8'(accept));
    chk("halt", 8'h00, 8'(halt));
    buf_short <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("busy", 8'h01, 8'(busy));
    host(2);
    chk("busy", 8'h00, 8'(busy));
    slow <= 1'b0;
    endtest("busy");
    // disconnect ended by UA, then by DM out of frame reject
    host(1);
    chk("state", 8'(LSC_ST_DISC), 8'(state));
    chk("disc", 8'(LSC_K_DISC), 8'(last.kind));
    rx(LSC_K_RR, 1'b0, 1'b1);
    chk("ignored", 8'h00, 8'(taken - take_b));
    rx(LSC_K_UA, 1'b0, 1'b1);
    chk("state", 8'(LSC_ST_ADM), 8'(state));
    chk("status", 8'h01, 8'(evt_n - evt_b));
    rx(LSC_K_SABM, 1'b1, 1'b0);
    chk_tx(LSC_K_UA, 1'b0);
    chk("state", 8'(LSC_ST_INFO), 8'(state));
    rx(LSC_K_I, 1'b1, 1'b0, 4'h2);
    host(1);
    chk("disc", 8'(LSC_K_DISC), 8'(last.kind));
    chk("frmr", 8'h00, 8'(frmr_act));
    chk("retry", 8'h00, retry_cnt);
    rx(LSC_K_DM, 1'b0, 1'b1);
    chk("state", 8'(LSC_ST_ADM), 8'(state));
    endtest("disconnect");
    // disconnect retries run out
    host(0);
    rx(LSC_K_UA, 1'b0, 1'b1);
    retry_limit <= 8'h01;
    host(1);
    wait_tx(8'h02, 200);
    chk("disc", 8'(LSC_K_DISC), 8'(last.kind));
    chk("retry", 8'h01, retry_cnt);
    for (int i = 0; i < 80 && state !== LSC_ST_ADM; i++) @(posedge clk_i);
    chk("state", 8'(LSC_ST_ADM), 8'(state));
    endtest("disconnect retries");
    // idle line detection
    chk("idle", 8'h00, 8'(chan_idle));
    idle <= 1'b1;
    for (int i = 0; i < 80 && chan_idle !== 1'b1; i++) @(posedge clk_i);
    chk("idle", 8'h01, 8'(chan_idle));
    idle <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk("idle", 8'h00, 8'(chan_idle));
    endtest("idle");
    results();
  end
endmodule
